// >>> actl_cal_control.sv
// How it works
// - With the source select at 0 the trigger level is the software bit, which resets to 1.
// - With the source select at 1 the trigger is the synchronised pin and the software bit is ignored.
// - In autonomous low-power mode the 3-bit sleep code picks 1,152 up to 1,099,511,627,904 periods.
// - While low-power calibration runs, the 2-bit wake code sets the settle time before calibration.
// - With trigger-driven sleep at 0 the sleep length comes from the sleep counter.
// - With trigger-driven sleep at 1 the core sleeps while the trigger is high and wakes when low.
// - Low-power enable acts only while background calibration is on.
// - The 8-bit gain trim drives the gain of all cores together.
// - The band-gap trim is the low nibble; the high nibble is reserved.
// - After reset the trims load from fuses and software may read and overwrite them.
// - The 8-bit channel A trim drives the first channel's termination.
//
// The AXI4-Lite interface to the registers is this design's own decision.
`timescale 1ns/10ps
`default_nettype none
module actl_cal_control
  import actl_pkg::*;
#(
  parameter logic [40:0] SLEEP_CYC_1 = SLEEP_PERIODS_1 * CYC_PER_PERIOD,
  parameter logic [40:0] SLEEP_CYC_2 = SLEEP_PERIODS_2 * CYC_PER_PERIOD,
  parameter logic [40:0] SLEEP_CYC_3 = SLEEP_PERIODS_3 * CYC_PER_PERIOD,
  parameter logic [40:0] SLEEP_CYC_4 = SLEEP_PERIODS_4 * CYC_PER_PERIOD,
  parameter logic [40:0] SLEEP_CYC_5 = SLEEP_PERIODS_5 * CYC_PER_PERIOD,
  parameter logic [40:0] SLEEP_CYC_6 = SLEEP_PERIODS_6 * CYC_PER_PERIOD,
  parameter logic [40:0] SLEEP_CYC_7 = SLEEP_PERIODS_7 * CYC_PER_PERIOD,
  parameter logic [40:0] WAKE_CYC_1  = WAKE_PERIODS_1 * CYC_PER_PERIOD,
  parameter logic [40:0] WAKE_CYC_2  = WAKE_PERIODS_2 * CYC_PER_PERIOD,
  parameter logic [40:0] WAKE_CYC_3  = WAKE_PERIODS_3 * CYC_PER_PERIOD
) (
  input  wire logic              clk,
  input  wire logic              resetn,
  // AXI4-Lite slave
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic              arvalid,
  output logic                   arready,
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready,
  // Calibration engine and pins
  input  wire logic              hardwareTriggerPin,
  input  wire actl_trim_t        fuseTrim,
  input  wire logic              calDone,
  output logic                   calTrigger,
  output logic                   calStart,
  output logic                   coreSleep,
  output actl_trim_t             trimOut
);

  // ------------------------------------------------------------------
  // State
  // ------------------------------------------------------------------
  actl_state_t st_r;
  actl_state_t st_nxt;

  // ------------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------------
  // Mapped indices; shared by the write and read paths
  function automatic logic regHit(input logic [9:0] idx);
    case (idx)
      IDX_PIN_CFG, IDX_SOFT_TRIG, IDX_LP_CTRL, IDX_BG_CTRL,
      IDX_STATUS, IDX_GAIN, IDX_BGAP, IDX_RES_A: regHit = 1'b1;
      default:                                   regHit = 1'b0;
    endcase
  endfunction : regHit

  // Sleep length per code
  function automatic logic [40:0] sleepCount(input logic [2:0] code);
    case (code)
      3'h0:    sleepCount = SLEEP_CYC_0;
      3'h1:    sleepCount = SLEEP_CYC_1;
      3'h2:    sleepCount = SLEEP_CYC_2;
      3'h3:    sleepCount = SLEEP_CYC_3;
      3'h4:    sleepCount = SLEEP_CYC_4;
      3'h5:    sleepCount = SLEEP_CYC_5;
      3'h6:    sleepCount = SLEEP_CYC_6;
      default: sleepCount = SLEEP_CYC_7;
    endcase
  endfunction : sleepCount

  // Settle length per code
  function automatic logic [40:0] wakeCount(input logic [1:0] code);
    case (code)
      2'h0:    wakeCount = WAKE_CYC_0;
      2'h1:    wakeCount = WAKE_CYC_1;
      2'h2:    wakeCount = WAKE_CYC_2;
      default: wakeCount = WAKE_CYC_3;
    endcase
  endfunction : wakeCount

  // Read mux; status shows the sequencer's own state
  function automatic logic [7:0] readByte(input logic [9:0]  idx,
                                          input actl_state_t s);
    case (idx)
      IDX_PIN_CFG:   readByte = s.pinCfg;
      IDX_SOFT_TRIG: readByte = s.softTrig;
      IDX_LP_CTRL:   readByte = s.lpCtrl;
      IDX_BG_CTRL:   readByte = s.bgCtrl;
      IDX_STATUS:    readByte = {3'h0, s.trimLoaded, s.coreSleep,
                                 s.hardware_trigger_pin, s.lpState};
      IDX_GAIN:      readByte = s.trim.gain;
      IDX_BGAP:      readByte = s.trim.bandgap;
      IDX_RES_A:     readByte = s.trim.resistorA;
      default:       readByte = 8'h00;
    endcase
  endfunction : readByte

  // ------------------------------------------------------------------
  // Derived controls
  // ------------------------------------------------------------------
  logic        lpActive;
  logic        trigMode;
  logic [40:0] sleepLoad;
  logic [40:0] wakeLoad;

  // Low-power is inert unless background calibration is on
  assign lpActive  = st_r.lpCtrl[LOW_POWER_CAL_ENABLE_BIT] & st_r.bgCtrl[BG_ON_BIT];
  assign trigMode  = st_r.lpCtrl[TRIGGER_DRIVEN_SLEEP_SELECT_BIT];
  assign sleepLoad = sleepCount(st_r.lpCtrl[SLEEP_MSB:SLEEP_LSB]);
  assign wakeLoad  = wakeCount(st_r.lpCtrl[WAKE_MSB:WAKE_LSB]);

  // ------------------------------------------------------------------
  // Next-state logic
  // ------------------------------------------------------------------
  always_comb begin
    st_nxt = st_r;

    // Two-flop pin synchroniser; only the second stage is read
    st_nxt.pinMeta = hardwareTriggerPin;
    st_nxt.pinSync = st_r.pinMeta;

    // Trigger source selection
    if (st_r.pinCfg[TRIG_SRC_BIT]) begin
      st_nxt.hardware_trigger_pin = st_r.pinSync;
    end else begin
      st_nxt.hardware_trigger_pin = st_r.softTrig[SOFT_TRIG_BIT];
    end

    // Fuse values land one edge after reset release
    if (!st_r.trimLoaded) begin
      st_nxt.trim       = fuseTrim;
      st_nxt.trimLoaded = 1'b1;
    end

    // Address and data channels are taken independently
    if (awvalid && awready) begin
      st_nxt.awHave = 1'b1;
      st_nxt.awIdx  = awaddr[11:2];
    end
    if (wvalid && wready) begin
      st_nxt.wHave  = 1'b1;
      st_nxt.wData  = wdata[7:0];
      st_nxt.wStrb0 = wstrb[0];
    end

    // Commit once both halves are held; a bus write wins over the fuse
    if (st_r.awHave && st_r.wHave && !st_r.bValid) begin
      st_nxt.awHave = 1'b0;
      st_nxt.wHave  = 1'b0;
      st_nxt.bValid = 1'b1;
      st_nxt.bResp  = regHit(st_r.awIdx) ? RESP_OKAY : RESP_SLVERR;
      if (st_r.wStrb0) begin
        case (st_r.awIdx)
          IDX_PIN_CFG:   st_nxt.pinCfg         = st_r.wData;
          IDX_SOFT_TRIG: st_nxt.softTrig       = st_r.wData;
          IDX_LP_CTRL:   st_nxt.lpCtrl         = st_r.wData;
          IDX_BG_CTRL:   st_nxt.bgCtrl         = st_r.wData;
          IDX_GAIN:      st_nxt.trim.gain      = st_r.wData;
          IDX_BGAP:      st_nxt.trim.bandgap   = st_r.wData;
          IDX_RES_A:     st_nxt.trim.resistorA = st_r.wData;
          // Status and unmapped indices keep the response set above
          default: ;
        endcase
      end
    end
    if (st_r.bValid && bready) begin
      st_nxt.bValid = 1'b0;
    end

    // Read channel, one outstanding at a time
    if (arvalid && !st_r.rValid) begin
      st_nxt.rValid = 1'b1;
      st_nxt.rData  = readByte(araddr[11:2], st_r);
      st_nxt.rResp  = regHit(araddr[11:2]) ? RESP_OKAY : RESP_SLVERR;
    end else if (st_r.rValid && rready) begin
      st_nxt.rValid = 1'b0;
    end

    // Low-power sequencer
    st_nxt.calStart = 1'b0;
    if (!lpActive) begin
      st_nxt.lpState  = LP_IDLE;
      st_nxt.delayCnt = 41'h0;
    end else begin
      unique case (st_r.lpState)
        LP_IDLE: begin
          st_nxt.lpState  = LP_SLEEP;
          st_nxt.delayCnt = sleepLoad;
        end
        LP_SLEEP: begin
          if (trigMode) begin
            // Level held by the trigger source decides the wake
            if (!st_r.hardware_trigger_pin) begin
              st_nxt.lpState  = LP_WAKE;
              st_nxt.delayCnt = wakeLoad;
            end
          end else if (st_r.delayCnt <= 41'h1) begin
            // Terminal count; <= covers a mode switch mid-sleep
            st_nxt.lpState  = LP_WAKE;
            st_nxt.delayCnt = wakeLoad;
          end else begin
            st_nxt.delayCnt = st_r.delayCnt - 41'h1;
          end
        end
        LP_WAKE: begin
          if (st_r.delayCnt <= 41'h1) begin
            st_nxt.lpState  = LP_CAL;
            st_nxt.calStart = 1'b1;
          end else begin
            st_nxt.delayCnt = st_r.delayCnt - 41'h1;
          end
        end
        LP_CAL: begin
          // Hold the core awake until the engine reports completion
          if (calDone) begin
            st_nxt.lpState  = LP_SLEEP;
            st_nxt.delayCnt = sleepLoad;
          end
        end
      endcase
    end
    st_nxt.coreSleep = (st_nxt.lpState == LP_SLEEP);
  end

  // ------------------------------------------------------------------
  // State register
  // ------------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_r            <= '0;
      st_r.pinCfg     <= RST_PIN_CFG;
      st_r.softTrig   <= RST_SOFT_TRIG;
      st_r.lpCtrl     <= RST_LP_CTRL;
      st_r.bgCtrl     <= RST_BG_CTRL;
      st_r.trim       <= {RST_TRIM, RST_TRIM, RST_TRIM};
      st_r.trimLoaded <= 1'b0;
      st_r.hardware_trigger_pin    <= 1'b1;
      st_r.lpState    <= LP_IDLE;
      st_r.bResp      <= RESP_OKAY;
      st_r.rResp      <= RESP_OKAY;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ------------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------------
  // Ready terms are combinational; everything else is a flop
  assign awready    = !st_r.awHave && !st_r.bValid;
  assign wready     = !st_r.wHave && !st_r.bValid;
  assign arready    = !st_r.rValid;
  assign bvalid     = st_r.bValid;
  assign bresp      = st_r.bResp;
  assign rvalid     = st_r.rValid;
  assign rresp      = st_r.rResp;
  assign rdata      = {24'h0, st_r.rData};
  assign calTrigger = st_r.hardware_trigger_pin;
  assign calStart   = st_r.calStart;
  assign coreSleep  = st_r.coreSleep;

  // Reserved upper nibble of the reference trim is stored, not driven
  assign trimOut.gain      = st_r.trim.gain;
  assign trimOut.bandgap   = {4'h0, st_r.trim.bandgap[BGAP_MSB:0]};
  assign trimOut.resistorA = st_r.trim.resistorA;

endmodule : actl_cal_control
`default_nettype wire

// >>> actl_cal_control_checker.sv
`timescale 1ns/10ps
`default_nettype none
module actl_cal_control_checker
  import actl_pkg::*;
(
  input wire logic              clk,
  input wire logic              resetn,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic              awvalid,
  input wire logic              awready,
  input wire logic [31:0]       wdata,
  input wire logic [3:0]        wstrb,
  input wire logic              wvalid,
  input wire logic              wready,
  input wire logic [1:0]        bresp,
  input wire logic              bvalid,
  input wire logic              bready,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic              arvalid,
  input wire logic              arready,
  input wire logic [31:0]       rdata,
  input wire logic [1:0]        rresp,
  input wire logic              rvalid,
  input wire logic              rready,
  input wire logic              hardwareTriggerPin,
  input wire actl_trim_t        fuseTrim,
  input wire logic              calDone,
  input wire logic              calTrigger,
  input wire logic              calStart,
  input wire logic              coreSleep,
  input wire actl_trim_t        trimOut
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  // ----------------------------------------------------------------
  // Sequencer and trims
  // ----------------------------------------------------------------
  a_bgap_upper: assert property (
    trimOut.bandgap[7:4] == 4'h0) else $error("bandgap upper bits set");
  a_fuse_load: assert property (
    !$past(resetn, 2) && $past(resetn) |-> trimOut == {$past(fuseTrim.gain),
    4'h0, $past(fuseTrim.bandgap[3:0]), $past(fuseTrim.resistorA)})
    else $error("trims not loaded from fuses");
  a_start_pulse: assert property (
    calStart |=> !calStart) else $error("calibration start too long");
  a_start_awake: assert property (
    calStart |-> !coreSleep && !$past(coreSleep))
    else $error("calibration started while asleep");
  // Shortest wake settle in any build is above eight cycles
  a_wake_settle: assert property (
    $fell(coreSleep) |-> !calStart [*8]) else $error("settle cut short");
  // ----------------------------------------------------------------
  // Register bus
  // ----------------------------------------------------------------
  a_bresp_hold: assert property (
    bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped");
  a_rdata_hold: assert property (
    rvalid && !rready |=> rvalid && $stable(rdata) && $stable(rresp))
    else $error("read data dropped");
  a_read_answer: assert property (
    arvalid && arready |=> rvalid) else $error("read answer late");
  a_write_answer: assert property (
    awvalid && awready && wvalid && wready |-> ##[1:2] bvalid)
    else $error("write answer late");
  a_rdata_upper: assert property (
    rvalid |-> rdata[31:8] == 24'h0) else $error("read upper bits set");
  c_sleep_end: cover property ($fell(coreSleep));
  c_cal_start: cover property (calStart);
  c_slverr: cover property (rvalid && rresp == RESP_SLVERR);
endmodule : actl_cal_control_checker
`default_nettype wire

// >>> actl_cal_control_note_end.sv
`default_nettype none
`default_nettype wire

// >>> actl_cal_control_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module actl_cal_control_tb_top
  import actl_pkg::*;
;
  logic              clk, resetn, bready, rready, calDone, trigLevel;
  logic              awvalid, awready, wvalid, wready, bvalid, arvalid;
  logic              arready, rvalid, hwPin, calTrigger, calStart, coreSleep;
  logic [ADDR_W-1:0] awaddr, araddr;
  logic [31:0]       wdata, rdata;
  logic [3:0]        wstrb;
  logic [1:0]        bresp, rresp;
  actl_trim_t        fuseTrim, trimOut;
  int                failCount, samplesChecked, n;
  localparam actl_trim_t FUSE = 24'h5a093c;
  // Short delays for codes 1 to 7; code 0 keeps its 1,152-cycle default, still measurable in one run
  actl_cal_control #(.SLEEP_CYC_1(41'd17), .SLEEP_CYC_2(41'd18),
    .SLEEP_CYC_3(41'd19), .SLEEP_CYC_4(41'd20), .SLEEP_CYC_5(41'd21),
    .SLEEP_CYC_6(41'd22), .SLEEP_CYC_7(41'd23), .WAKE_CYC_1(41'd9),
    .WAKE_CYC_2(41'd10), .WAKE_CYC_3(41'd11)) dut_u (.clk(clk),
    .resetn(resetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .hardwareTriggerPin(hwPin),
    .fuseTrim(fuseTrim), .calDone(calDone), .calTrigger(calTrigger),
    .calStart(calStart), .coreSleep(coreSleep), .trimOut(trimOut));
  actl_trig_src_model #(.LAG(2)) trig_u (.clk(clk), .level(trigLevel),
    .pin(hwPin));
  // ----------------------------------------------------------------
  // Checks and bus tasks
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [40:0] e,
                     input logic [40:0] g);
    samplesChecked++;
    if (g !== e) begin
      failCount++;
      $display("unexpected %s: expected %0h, seen %0h", nm, e, g);
    end
  endtask : chk
  task automatic finishTest;
    $display("checks %0d, mismatches %0d", samplesChecked, failCount);
    if (failCount == 0 && samplesChecked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : finishTest
  // Every wait is bounded; a hang ends the run as a mismatch
  task automatic stall(inout int c);
    c++;
    if (c > 5000) begin
      chk("wait", 41'h0, 41'h1);
      finishTest();
    end
  endtask : stall
  task automatic busWr(input logic [9:0] idx, input logic [7:0] d,
                       input logic [1:0] er, input logic [3:0] s = 4'h1);
    int c;
    c = 0;
    awaddr  <= {idx, 2'b00};
    wdata   <= {24'hc3c3c3, d};
    wstrb   <= s;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      stall(c);
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk("bresp", er, bresp);
    @(posedge clk);
  endtask : busWr
  task automatic busRd(input logic [9:0] idx, input logic [7:0] d,
                       input logic [1:0] er);
    int c;
    c = 0;
    araddr  <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
      stall(c);
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
    chk("rresp", er, rresp);
    if (er == RESP_OKAY) chk("rdata", {24'h0, d}, rdata);
    @(posedge clk);
  endtask : busRd
  // Cycles asleep, then cycles settling until calibration starts
  task automatic measure(input logic [40:0] es, input logic [40:0] ew);
    int c;
    logic [40:0] t;
    c = 0;
    t = '0;
    while (coreSleep !== 1'b1) begin @(posedge clk); stall(c); end
    while (coreSleep === 1'b1) begin t++; @(posedge clk); stall(c); end
    chk("sleep cycles", es, t);
    t = '0;
    while (calStart !== 1'b1) begin t++; @(posedge clk); stall(c); end
    chk("wake cycles", ew, t);
    calDone <= 1'b1;
    @(posedge clk);
    calDone <= 1'b0;
  endtask : measure
  // ----------------------------------------------------------------
  // Stimulus
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  initial begin
    {resetn, awvalid, wvalid, bready, arvalid, rready} = '0;
    {calDone, trigLevel, awaddr, araddr, wdata, wstrb} = '0;
    {failCount, samplesChecked} = '0;
    fuseTrim = FUSE;
    repeat (20) @(posedge clk);
    resetn <= 1'b1;
    repeat (2) @(posedge clk);
    chk("calTrigger", 1'b1, calTrigger);
    chk("trimOut", FUSE, trimOut);
    busRd(IDX_PIN_CFG, RST_PIN_CFG, RESP_OKAY);
    busRd(IDX_SOFT_TRIG, RST_SOFT_TRIG, RESP_OKAY);
    busRd(IDX_LP_CTRL, RST_LP_CTRL, RESP_OKAY);
    busRd(IDX_GAIN, 8'h5a, RESP_OKAY);
    busRd(IDX_BGAP, 8'h09, RESP_OKAY);
    busRd(IDX_RES_A, 8'h3c, RESP_OKAY);
    busRd(10'h07b, 8'h00, RESP_SLVERR);
    busWr(10'h07b, 8'hff, RESP_SLVERR);
    busWr(IDX_GAIN, 8'ha5, RESP_OKAY);
    busWr(IDX_GAIN, 8'h77, RESP_OKAY, 4'h0);
    busRd(IDX_GAIN, 8'ha5, RESP_OKAY);
    busWr(IDX_BGAP, 8'hf3, RESP_OKAY);
    busWr(IDX_RES_A, 8'h81, RESP_OKAY);
    chk("trimOut", 24'ha50381, trimOut);
    busRd(IDX_BGAP, 8'hf3, RESP_OKAY);
    busWr(IDX_SOFT_TRIG, 8'h00, RESP_OKAY);
    chk("calTrigger", 1'b0, calTrigger);
    trigLevel <= 1'b1;
    repeat (8) @(posedge clk);
    chk("calTrigger", 1'b0, calTrigger);
    busWr(IDX_PIN_CFG, 8'h01, RESP_OKAY);
    chk("calTrigger", 1'b1, calTrigger);
    busWr(IDX_SOFT_TRIG, 8'h01, RESP_OKAY);
    trigLevel <= 1'b0;
    repeat (8) @(posedge clk);
    chk("calTrigger", 1'b0, calTrigger);
    busWr(IDX_PIN_CFG, 8'h00, RESP_OKAY);
    chk("calTrigger", 1'b1, calTrigger);
    busWr(IDX_LP_CTRL, 8'h89, RESP_OKAY);
    n = 0;
    repeat (40) begin @(posedge clk); if (coreSleep !== 1'b0) n++; end
    chk("sleep while off", 0, n);
    busWr(IDX_BG_CTRL, 8'h01, RESP_OKAY);
    for (int k = 0; k < 8; k++) begin
      busWr(IDX_LP_CTRL, 8'h00, RESP_OKAY);
      busWr(IDX_LP_CTRL, {k[2:0], 2'(k % 4), 3'b001}, RESP_OKAY);
      measure(k == 0 ? SLEEP_CYC_0 : 41'(16 + k),
              k % 4 == 0 ? WAKE_CYC_0 : 41'(8 + k % 4));
    end
    busWr(IDX_LP_CTRL, 8'h00, RESP_OKAY);
    busWr(IDX_PIN_CFG, 8'h01, RESP_OKAY);
    trigLevel <= 1'b1;
    repeat (8) @(posedge clk);
    busWr(IDX_LP_CTRL, 8'h8b, RESP_OKAY);
    repeat (40) @(posedge clk);
    chk("coreSleep", 1'b1, coreSleep);
    trigLevel <= 1'b0;
    n = 0;
    while (coreSleep === 1'b1 && n < 20) begin @(posedge clk); n++; end
    chk("wake on low", 1'b1, n < 9);
    // New fuse word must not land until the next reset
    fuseTrim <= 24'h1e0762;
    repeat (2) @(posedge clk);
    chk("trimOut", 24'ha50381, trimOut);
    resetn <= 1'b0;
    repeat (3) @(posedge clk);
    chk("coreSleep", 1'b0, coreSleep);
    resetn <= 1'b1;
    repeat (2) @(posedge clk);
    chk("trimOut", 24'h1e0762, trimOut);
    busRd(IDX_LP_CTRL, RST_LP_CTRL, RESP_OKAY);
    busRd(IDX_BGAP, 8'h07, RESP_OKAY);
    finishTest();
  end
endmodule : actl_cal_control_tb_top
bind actl_cal_control actl_cal_control_checker chk_u (.clk(clk),
  .resetn(resetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
  .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
  .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
  .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
  .rvalid(rvalid), .rready(rready), .calDone(calDone),
  .hardwareTriggerPin(hardwareTriggerPin), .fuseTrim(fuseTrim),
  .calTrigger(calTrigger), .calStart(calStart), .coreSleep(coreSleep),
  .trimOut(trimOut));
`default_nettype wire

// >>> actl_pkg.sv
`default_nettype none
package actl_pkg;

  // ------------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ------------------------------------------------------------------
  localparam int         ADDR_W        = 12;
  localparam logic [9:0] IDX_PIN_CFG   = 10'h06b;
  localparam logic [9:0] IDX_SOFT_TRIG = 10'h06c;
  localparam logic [9:0] IDX_LP_CTRL   = 10'h06e;
  localparam logic [9:0] IDX_BG_CTRL   = 10'h070;
  localparam logic [9:0] IDX_STATUS    = 10'h071;
  localparam logic [9:0] IDX_GAIN      = 10'h07a;
  localparam logic [9:0] IDX_BGAP      = 10'h07c;
  localparam logic [9:0] IDX_RES_A     = 10'h07e;

  // ------------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------------
  localparam logic [7:0] RST_PIN_CFG   = 8'h00;
  localparam logic [7:0] RST_SOFT_TRIG = 8'h01;
  localparam logic [7:0] RST_LP_CTRL   = 8'h88;
  localparam logic [7:0] RST_BG_CTRL   = 8'h00;
  localparam logic [7:0] RST_TRIM      = 8'h00;

  // ------------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------------
  localparam int TRIG_SRC_BIT  = 0;
  localparam int SOFT_TRIG_BIT = 0;
  localparam int BG_ON_BIT     = 0;
  localparam int LOW_POWER_CAL_ENABLE_BIT     = 0;
  localparam int TRIGGER_DRIVEN_SLEEP_SELECT_BIT   = 1;
  localparam int WAKE_LSB      = 3;
  localparam int WAKE_MSB      = 4;
  localparam int SLEEP_LSB     = 5;
  localparam int SLEEP_MSB     = 7;
  localparam int BGAP_MSB      = 3;

  // ------------------------------------------------------------------
  // Delays, in converter clock periods; clk is that clock
  // ------------------------------------------------------------------
  localparam logic [40:0] CYC_PER_PERIOD   = 41'h1;
  localparam logic [40:0] SLEEP_PERIODS_0  = 41'h480;
  localparam logic [40:0] SLEEP_PERIODS_1  = 41'h400080;
  localparam logic [40:0] SLEEP_PERIODS_2  = 41'h2000080;
  localparam logic [40:0] SLEEP_PERIODS_3  = 41'h10000080;
  localparam logic [40:0] SLEEP_PERIODS_4  = 41'h80000080;
  localparam logic [40:0] SLEEP_PERIODS_5  = 41'h400000080;
  localparam logic [40:0] SLEEP_PERIODS_6  = 41'h2000000080;
  localparam logic [40:0] SLEEP_PERIODS_7  = 41'h10000000080;
  localparam logic [40:0] WAKE_PERIODS_0   = 41'h480;
  localparam logic [40:0] WAKE_PERIODS_1   = 41'h2000080;
  localparam logic [40:0] WAKE_PERIODS_2   = 41'h10000080;
  localparam logic [40:0] WAKE_PERIODS_3   = 41'h80000080;
  localparam logic [40:0] SLEEP_CYC_0 = SLEEP_PERIODS_0 * CYC_PER_PERIOD;
  localparam logic [40:0] WAKE_CYC_0  = WAKE_PERIODS_0 * CYC_PER_PERIOD;

  // ------------------------------------------------------------------
  // Bus responses and types
  // ------------------------------------------------------------------
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    LP_IDLE  = 2'h0,
    LP_SLEEP = 2'h1,
    LP_WAKE  = 2'h3,
    LP_CAL   = 2'h2
  } actl_lp_state_t;

  typedef struct packed {
    logic [7:0] gain;
    logic [7:0] bandgap;
    logic [7:0] resistorA;
  } actl_trim_t;

  typedef struct packed {
    logic [7:0]     pinCfg;
    logic [7:0]     softTrig;
    logic [7:0]     lpCtrl;
    logic [7:0]     bgCtrl;
    actl_trim_t     trim;
    logic           trimLoaded;
    logic           pinMeta;
    logic           pinSync;
    logic           hardware_trigger_pin;
    actl_lp_state_t lpState;
    logic [40:0]    delayCnt;
    logic           calStart;
    logic           coreSleep;
    logic           awHave;
    logic [9:0]     awIdx;
    logic           wHave;
    logic [7:0]     wData;
    logic           wStrb0;
    logic           bValid;
    logic [1:0]     bResp;
    logic           rValid;
    logic [7:0]     rData;
    logic [1:0]     rResp;
  } actl_state_t;

endpackage : actl_pkg
`default_nettype wire

// >>> actl_trig_src_model.sv
`timescale 1ns/10ps
`default_nettype none
module actl_trig_src_model #(
  parameter int LAG = 2
) (
  input  wire logic clk,
  input  wire logic level,
  output logic      pin
);
  logic [LAG-1:0] pipe_r = '0;
  // Slow external driver: level shows LAG clocks late, no glitches
  always @(posedge clk) begin
    pipe_r <= {pipe_r[LAG-2:0], level};
  end
  assign pin = pipe_r[LAG-1];
endmodule : actl_trig_src_model
`default_nettype wire
